// ===== hw/vcd_pkg.sv
// package: constants and carriers for the backplane-voltage calibration dac serial slave
package vcd_pkg;
  localparam int          DAC_W         = 7;
  localparam logic [6:0]  SLAVE_ADDR    = 7'h4E;
  localparam logic [3:0]  BYTE_LAST_BIT = 4'h7;
  localparam logic [3:0]  ACK_BIT       = 4'h8;
  localparam logic [DAC_W-1:0] DAC_CODE_MIN = 7'h00;
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          PROG_TIME_NS  = 10_000;
  localparam int          PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    VCD_IDLE,
    VCD_ADDR,
    VCD_ADDR_ACK,
    VCD_RD_DATA,
    VCD_RD_ACK,
    VCD_WR_DATA,
    VCD_WR_ACK,
    VCD_WAIT_STOP
  } vcd_state_t;

  // one programming request to the nonvolatile store
  typedef struct packed {
    logic             start;
    logic [DAC_W-1:0] code;
  } vcd_prog_req_t;
endpackage : vcd_pkg

// ===== hw/vcd_i2c_slave.sv
// serial slave for the backplane-voltage calibration dac with nonvolatile commit
//
// Functional notes
// [R1] address 1001110 then direction bit
// [R2] ack address only on match, not programming
// [R3] read returns seven code bits then zero
// [R4] master writes code then one bit
// [R5] final zero bit commands nonvolatile programming
// [R6] no ack nor program below gate-on threshold
// [R7] dac code maps linearly to sink current
// [R8] ack every received byte once addressed; refused program commands get no ack
// [R9] ack holds data low through clock high
// [R10] master nack ends read; release data line
// [R11] no ack during nonvolatile write cycle
// [R12] address polling acked once cycle done
// [R13] program only if code changed since last
// [R14] exactly address byte plus one data byte
// [R15] start and stop detected while clock high
// [R16] data changes only while clock low
// [R17] reset loads code from nonvolatile store
`timescale 1ns/100ps
module vcd_i2c_slave #(
  parameter int PROG_CYCLES = vcd_pkg::PROG_CYCLES
) (
  input  wire logic                       mclk_in,
  input  wire logic                       rst_in,
  input  wire logic                       scl_in,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe_out,
  input  wire logic                       gate_on_supply_ok_in,
  input  wire logic [vcd_pkg::DAC_W-1:0]  nonvolatile_store_code_in,
  output logic [vcd_pkg::DAC_W-1:0]       sink_current_code_out,
  output vcd_pkg::vcd_prog_req_t          nonvolatile_store_prog_out,
  output logic                            prog_busy_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] scl_sync_q, scl_sync_d;
  logic [1:0] sda_sync_q, sda_sync_d;
  logic [1:0] gon_sync_q, gon_sync_d;
  logic       scl_prev_q, scl_prev_d;
  logic       sda_prev_q, sda_prev_d;

  always_comb begin
    scl_sync_d = {scl_sync_q[0], scl_in};
    sda_sync_d = {sda_sync_q[0], sda_in};
    gon_sync_d = {gon_sync_q[0], gate_on_supply_ok_in};
    scl_prev_d = scl_sync_q[1];
    sda_prev_d = sda_sync_q[1];
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      gon_sync_q <= 2'h0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= scl_sync_d;
      sda_sync_q <= sda_sync_d;
      gon_sync_q <= gon_sync_d;
      scl_prev_q <= scl_prev_d;
      sda_prev_q <= sda_prev_d;
    end
  end

  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  always_comb begin
    scl_s     = scl_sync_q[1];
    sda_s     = sda_sync_q[1];
    scl_rise  = scl_s & ~scl_prev_q;
    scl_fall  = ~scl_s & scl_prev_q;
    // [R15] start stop detect
    start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // protocol engine, code register and programming timer
  localparam int PW = $clog2(PROG_CYCLES + 1);

  vcd_pkg::vcd_state_t          state_q, state_d;
  logic [3:0]                   bit_q, bit_d;
  logic [7:0]                   shift_q, shift_d;
  logic                         drive_low_q, drive_low_d;
  logic                         rd_q, rd_d;
  logic [vcd_pkg::DAC_W-1:0]    code_q, code_d;
  logic                         modified_q, modified_d;
  logic                         loaded_q, loaded_d;
  logic [PW-1:0]                prog_cnt_q, prog_cnt_d;
  vcd_pkg::vcd_prog_req_t       prog_q, prog_d;
  logic                         busy;
  logic                         busy_out_q, busy_out_d;

  always_comb begin
    state_d     = state_q;
    bit_d       = bit_q;
    shift_d     = shift_q;
    drive_low_d = drive_low_q;
    rd_d        = rd_q;
    code_d      = code_q;
    modified_d  = modified_q;
    loaded_d    = 1'b1;
    prog_cnt_d  = prog_cnt_q;
    prog_d      = '{start: 1'b0, code: prog_q.code};
    busy        = (prog_cnt_q != '0);

    // [R17] load from store
    if (!loaded_q) begin
      code_d     = nonvolatile_store_code_in;
      modified_d = 1'b0;
    end

    // [R11] internal write cycle
    if (busy) begin
      prog_cnt_d = prog_cnt_q - PW'(1);
    end

    if (start_det) begin
      // repeated start also lands here, so polling restarts address capture
      state_d     = vcd_pkg::VCD_ADDR;
      bit_d       = '0;
      drive_low_d = 1'b0;
    end else if (stop_det) begin
      state_d     = vcd_pkg::VCD_IDLE;
      drive_low_d = 1'b0;
    end else begin
      unique case (state_q)
        vcd_pkg::VCD_IDLE, vcd_pkg::VCD_WAIT_STOP: begin
          drive_low_d = 1'b0;
        end
        vcd_pkg::VCD_ADDR, vcd_pkg::VCD_WR_DATA: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s};
            bit_d   = bit_q + 4'h1;
          end
          // [R16] act on low phase
          if (scl_fall && bit_q == vcd_pkg::ACK_BIT) begin
            bit_d = '0;
            if (state_q == vcd_pkg::VCD_ADDR) begin
              // [R1] address match
              // [R2] ack gating
              // [R12] poll ack
              if (shift_q[7:1] == vcd_pkg::SLAVE_ADDR && !busy) begin
                drive_low_d = 1'b1;
                rd_d        = shift_q[0];
                state_d     = vcd_pkg::VCD_ADDR_ACK;
              end else begin
                state_d = vcd_pkg::VCD_WAIT_STOP;
              end
            end else if (shift_q[0]) begin
              // [R4] update only
              // [R8] ack data byte
              drive_low_d = 1'b1;
              if (shift_q[7:1] != code_q) begin
                modified_d = 1'b1;
              end
              code_d  = shift_q[7:1];
              state_d = vcd_pkg::VCD_WR_ACK;
            // [R5] program command
            // [R6] gate-on threshold
            // [R13] changed since last
            end else if (gon_sync_q[1] && !busy
                         && (modified_q || shift_q[7:1] != code_q)) begin
              drive_low_d = 1'b1;
              code_d      = shift_q[7:1];
              modified_d  = 1'b0;
              prog_d      = '{start: 1'b1, code: shift_q[7:1]};
              prog_cnt_d  = PW'(PROG_CYCLES);
              state_d     = vcd_pkg::VCD_WR_ACK;
            end else begin
              state_d = vcd_pkg::VCD_WAIT_STOP;
            end
          end
        end
        vcd_pkg::VCD_ADDR_ACK: begin
          // [R9] hold ack low
          if (scl_fall) begin
            bit_d = '0;
            if (rd_q) begin
              // [R3] code then zero
              shift_d     = {code_q, 1'b0};
              drive_low_d = ~code_q[vcd_pkg::DAC_W-1];
              state_d     = vcd_pkg::VCD_RD_DATA;
            end else begin
              drive_low_d = 1'b0;
              state_d     = vcd_pkg::VCD_WR_DATA;
            end
          end
        end
        vcd_pkg::VCD_RD_DATA: begin
          if (scl_fall) begin
            if (bit_q == vcd_pkg::BYTE_LAST_BIT) begin
              // [R10] release for master ack
              drive_low_d = 1'b0;
              state_d     = vcd_pkg::VCD_RD_ACK;
            end else begin
              shift_d     = {shift_q[6:0], 1'b0};
              drive_low_d = ~shift_q[6];
              bit_d       = bit_q + 4'h1;
            end
          end
        end
        vcd_pkg::VCD_RD_ACK, vcd_pkg::VCD_WR_ACK: begin
          // [R14] one data byte only
          if (scl_fall) begin
            drive_low_d = 1'b0;
            state_d     = vcd_pkg::VCD_WAIT_STOP;
          end
        end
      endcase
    end
    // registered copy so the busy pin never shows a raw compare glitch
    busy_out_d = (prog_cnt_d != '0);
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_q     <= vcd_pkg::VCD_IDLE;
      bit_q       <= '0;
      shift_q     <= '0;
      drive_low_q <= 1'b0;
      rd_q        <= 1'b0;
      code_q      <= vcd_pkg::DAC_CODE_MIN;
      modified_q  <= 1'b0;
      loaded_q    <= 1'b0;
      prog_cnt_q  <= '0;
      prog_q      <= '0;
      busy_out_q  <= 1'b0;
    end else begin
      state_q     <= state_d;
      bit_q       <= bit_d;
      shift_q     <= shift_d;
      drive_low_q <= drive_low_d;
      rd_q        <= rd_d;
      code_q      <= code_d;
      modified_q  <= modified_d;
      loaded_q    <= loaded_d;
      prog_cnt_q  <= prog_cnt_d;
      prog_q      <= prog_d;
      busy_out_q  <= busy_out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs: sda_out tied low, all others registered
  always_comb begin
    sda_out                    = 1'b0;
    sda_oe_out                 = drive_low_q;
    // [R7] linear code to sink current
    sink_current_code_out      = code_q;
    nonvolatile_store_prog_out = prog_q;
    prog_busy_out              = busy_out_q;
  end
endmodule : vcd_i2c_slave

// ===== bench/vcd_slave_sva.sv
// checker: port timing relations of the dac serial slave
`timescale 1ns/100ps
module vcd_slave_sva #(
  parameter int PROG_CYCLES = vcd_pkg::PROG_CYCLES
) (
  input wire logic                          mclk_in,
  input wire logic                          rst_in,
  input wire logic                          scl_in,
  input wire logic                          sda_in,
  input wire logic                          sda_out,
  input wire logic                          sda_oe_out,
  input wire logic                          gate_on_supply_ok_in,
  input wire logic [vcd_pkg::DAC_W-1:0]     nonvolatile_store_code_in,
  input wire logic [vcd_pkg::DAC_W-1:0]     sink_current_code_out,
  input wire vcd_pkg::vcd_prog_req_t        nonvolatile_store_prog_out,
  input wire logic                          prog_busy_out
);
  int busy_q;
  int busy_d;
  always_comb busy_d = prog_busy_out ? busy_q + 1 : 0;
  always_ff @(posedge mclk_in) busy_q <= rst_in ? 0 : busy_d;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////////////
  sequence prog_cmd; nonvolatile_store_prog_out.start; endsequence
  sequence busy_run; prog_busy_out [*8]; endsequence
  a_reset_load: assert property (
    $past(rst_in) |=> sink_current_code_out == $past(nonvolatile_store_code_in))
    else $error("code not loaded after reset");
  a_sda_low_only: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_oe_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data changed while clock high");
  a_prog_acked: assert property (prog_cmd |-> ##[0:3] sda_oe_out)
    else $error("program command not acknowledged");
  a_prog_supply: assert property (prog_cmd |-> gate_on_supply_ok_in)
    else $error("program with supply low");
  a_prog_code: assert property (
    prog_cmd |-> ##[0:3] sink_current_code_out == nonvolatile_store_prog_out.code)
    else $error("program code differs from dac code");
  a_busy_start: assert property (prog_cmd |=> ##[0:2] busy_run)
    else $error("busy missing after program");
  a_busy_len: assert property (busy_q <= PROG_CYCLES)
    else $error("busy too long");
  a_busy_full: assert property ($fell(prog_busy_out) |-> busy_q == PROG_CYCLES)
    else $error("busy ended early");
  a_no_ack_busy: assert property (
    prog_busy_out && $past(prog_busy_out, 4) |-> !$rose(sda_oe_out))
    else $error("acknowledge while programming");
  a_no_prog_busy: assert property ($past(prog_busy_out) |-> !prog_cmd)
    else $error("program started while busy");
endmodule : vcd_slave_sva
bind vcd_i2c_slave vcd_slave_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (.mclk_in, .rst_in,
  .scl_in, .sda_in, .sda_out, .sda_oe_out, .gate_on_supply_ok_in, .nonvolatile_store_code_in,
  .sink_current_code_out, .nonvolatile_store_prog_out, .prog_busy_out);

// ===== bench/vcd_bus_master.sv
// partner: two-wire bus master with open-drain data
`timescale 1ns/100ps
module vcd_bus_master (
  output logic      scl_out,
  output logic      sda_oe_out,
  input  wire logic sda_in
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic cond(input logic stop);
    sda_oe_out = stop;
    #31 scl_out = 1'b1;
    #31 sda_oe_out = ~stop;
    #31 scl_out = stop;
    #31;
  endtask : cond
  // one bit per pulse, ninth for ack
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_oe_out = ~tx[i];
      #31 scl_out = 1'b1;
      #31 rx[i] = sda_in;
      #31 scl_out = 1'b0;
      #32;
    end
  endtask : xfer
endmodule : vcd_bus_master

// ===== bench/tb_top.sv
// testbench: bus master exercises the dac serial slave
`timescale 1ns/100ps
module tb_top;
  logic                   mclk_in = 1'b0;
  logic                   rst_in  = 1'b1;
  logic                   supply  = 1'b1;
  logic [6:0]             code;
  logic                   m_oe, dut_oe, busy, scl;
  wire                    sda;
  vcd_pkg::vcd_prog_req_t prog;
  int                     fails = 0, check_count = 0, prog_n = 0;
  logic [8:0]             ra, rd;
  logic [6:0]             nv_code = 7'h2A;
  always #4 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (prog.start === 1'b1) prog_n <= prog_n + 1;
  // pull-up on the data wire
  assign sda = ~(m_oe | dut_oe);
  vcd_i2c_slave #(.PROG_CYCLES(1000)) DUT (.mclk_in(mclk_in), .rst_in(rst_in),
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_out(dut_oe),
    .gate_on_supply_ok_in(supply), .nonvolatile_store_code_in(nv_code),
    .sink_current_code_out(code), .nonvolatile_store_prog_out(prog), .prog_busy_out(busy));
  vcd_bus_master mst (.scl_out(scl), .sda_oe_out(m_oe), .sda_in(sda));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // both bytes with the master releasing data on each ack bit
  task automatic trans(input logic [7:0] a, input logic [7:0] d);
    mst.cond(1'b0);
    mst.xfer({a, 1'b1}, ra);
    mst.xfer({d, 1'b1}, rd);
    mst.cond(1'b1);
  endtask : trans
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_bad_addr();
    trans(8'hA0, 8'h2B);
    chk(ra, 9'h141);
    chk(rd, 9'h057);
  endtask : t_bad_addr
  task automatic t_read();
    trans(8'h9D, 8'hFF);
    chk(ra, 9'h13A);
    chk(rd, 9'h0A9);
  endtask : t_read
  task automatic t_update();
    trans(8'h9C, 8'h2B);
    chk(rd, 9'h056);
    chk({2'h0, code}, 9'h015);
    chk(9'(prog_n), 9'h000);
  endtask : t_update
  task automatic t_prog_low();
    @(negedge mclk_in) supply = 1'b0;
    trans(8'h9C, 8'h2A);
    chk(rd, 9'h055);
    chk(9'(prog_n), 9'h000);
    @(negedge mclk_in) supply = 1'b1;
  endtask : t_prog_low
  task automatic t_prog_poll();
    trans(8'h9C, 8'h2A);
    chk(rd, 9'h054);
    chk(9'(prog_n), 9'h001);
    chk({2'h0, prog.code}, 9'h015);
    chk({8'h00, busy}, 9'h001);
    trans(8'h9D, 8'hFF);
    chk(ra, 9'h13B);
    // bounded poll: a device stuck busy shows up as a mismatch below
    for (int i = 0; i < 10 && ra[0] !== 1'b0; i++) trans(8'h9D, 8'hFF);
    chk({8'h00, ra[0]}, 9'h000);
    chk(rd, 9'h055);
    chk({8'h00, busy}, 9'h000);
  endtask : t_prog_poll
  task automatic t_prog_same();
    trans(8'h9C, 8'h2A);
    chk(rd, 9'h055);
    chk(9'(prog_n), 9'h001);
  endtask : t_prog_same
  // mid-run reset with a new stored code; the reloaded code counts as unmodified
  task automatic t_reset_reload();
    @(negedge mclk_in) rst_in = 1'b1;
    nv_code = 7'h33;
    repeat (3) @(negedge mclk_in);
    rst_in = 1'b0;
    repeat (8) @(negedge mclk_in);
    chk({2'h0, code}, 9'h033);
    trans(8'h9C, 8'h66);
    chk(ra, 9'h138);
    chk(rd, 9'h0CD);
    chk(9'(prog_n), 9'h001);
  endtask : t_reset_reload
  initial begin
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in) rst_in = 1'b0;
    repeat (8) @(negedge mclk_in);
    chk({2'h0, code}, 9'h02A);
    t_bad_addr();
    t_read();
    t_update();
    t_prog_low();
    t_prog_poll();
    t_prog_same();
    t_reset_reload();
    tally_and_finish();
  end
endmodule : tb_top
